// ==== analog_load_model.sv ====
`timescale 1ns/1ps
// Load on the output pin: a released driver leaves the pin to the resistor
module analog_load_model (
	input  wire logic [11:0] dac_code_i,
	input  wire logic        out_en_i,
	input  wire logic        pull_up_i,
	output logic      [11:0] pin_level_o
);
	// Driven pin follows the code; a floating pin sits at the band edge
	always_comb begin
		if (out_en_i === 1'b1) begin
			pin_level_o = dac_code_i;
		end else begin
			pin_level_o = pull_up_i ? 12'hFFF : 12'h000;
		end
	end
endmodule

// ==== angle_map_pkg.sv ====
package angle_map_pkg;
	// Data path widths
	localparam int ANG_W   = 14;
	localparam int DAC_W   = 12;
	localparam int CLAMP_W = 9;
	localparam int PAD_W   = DAC_W - CLAMP_W;
	localparam logic [PAD_W-1:0] CLAMP_LO_PAD = 3'h0;
	localparam logic [PAD_W-1:0] CLAMP_HI_PAD = 3'h7;
	// Failure band codes: 0 % and 100 % of the supply span
	localparam logic [DAC_W-1:0] FAIL_LOW_CODE  = 12'h000;
	localparam logic [DAC_W-1:0] FAIL_HIGH_CODE = 12'hFFF;
	// Register byte offsets
	localparam logic [7:0] ADR_CFG0   = 8'h00;
	localparam logic [7:0] ADR_CFG3   = 8'h0C;
	localparam logic [7:0] ADR_STATUS = 8'h10;
	localparam logic [7:0] ADR_LIVE   = 8'h14;
	localparam int OTP_WORDS = 4;
	// Field positions inside the configuration words
	localparam int F_LO      = 0;
	localparam int F_HI      = 16;
	localparam int F_INVERT  = 16;
	localparam int F_BAND    = 17;
	localparam int F_LOCK    = 31;
	// Power-up values of the four configuration words
	localparam logic [31:0] CFG0_DEF = 32'h3FFF_0000;
	localparam logic [31:0] CFG1_DEF = 32'h0FFF_0000;
	localparam logic [31:0] CFG2_DEF = 32'h01FF_0000;
	localparam logic [31:0] CFG3_DEF = 32'h0000_0000;
	// Timing: times in ns, counts derived from the clock period except WD_REC_CYC, fixed at 1
	localparam int CLK_NS    = 20;
	localparam int OV_DET_NS = 250000;
	localparam int OV_REC_NS = 250000;
	localparam int UV_DET_NS = 250000;
	localparam int UV_REC_NS = 250000;
	localparam int WD_DET_NS = 12000000;
	localparam int OV_DET_CYC = OV_DET_NS / CLK_NS;
	localparam int OV_REC_CYC = OV_REC_NS / CLK_NS;
	localparam int UV_DET_CYC = UV_DET_NS / CLK_NS;
	localparam int UV_REC_CYC = UV_REC_NS / CLK_NS;
	localparam int WD_DET_CYC = WD_DET_NS / CLK_NS;
	localparam int WD_REC_CYC = 1;
	// Qualifier states
	typedef enum logic [1:0] {
		Q_OK    = 2'b01,
		Q_FAULT = 2'b10
	} qual_state_t;
endpackage

// ==== angle_output_mapper.sv ====
`timescale 1ns/1ps
// Contract
// [RQ1] Input is a 14-bit binary angle code
// [RQ2] Mapped result feeds 12-bit supply-referenced DAC
// [RQ3] Start and end angles held at 14 bits
// [RQ4] Independent 9-bit low and high clamps
// [RQ5] 12-bit output levels at start and end
// [RQ6] Slope from points, extended to low clamp
// [RQ7] Output steps high to low at break point
// [RQ8] 14-bit break point moves the wrap transition
// [RQ9] Programmable slope inversion reverses rotation direction
// [RQ10] Overvoltage beyond detection time turns output off
// [RQ11] Overvoltage recovery re-enables after recovery time
// [RQ12] Undervoltage beyond detection time turns output off
// [RQ13] Undervoltage recovery re-enables after qualification time
// [RQ14] Watchdog error detected within 12 ms
// [RQ15] Output overload puts driver in high impedance
// [RQ16] Failures float output or drive failure band
// [RQ17] Configuration writable anytime, defaults at power-up
// [RQ18] Lock bit freezes configuration permanently; here only until reset_i reloads CFG3_DEF with the lock bit clear
// [RQ19] Lock bit selects analog output mode
// [RQ20] Parameters held in 128-bit one-time memory; here four 32-bit registers, rewritable while unlocked and reloaded by reset_i
// [RQ21] Internal alarms go to band chosen by bit
// [RQ22] Low band 0-4 %, high band 96-100 %
// [RQ23] Clamps compare against top 9 output bits
module angle_output_mapper #(
	parameter int OV_DET = angle_map_pkg::OV_DET_CYC,
	parameter int OV_REC = angle_map_pkg::OV_REC_CYC,
	parameter int UV_DET = angle_map_pkg::UV_DET_CYC,
	parameter int UV_REC = angle_map_pkg::UV_REC_CYC,
	parameter int WD_DET = angle_map_pkg::WD_DET_CYC
) (
	input  wire logic        core_clk_i,
	input  wire logic        reset_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [13:0] angle_i,
	input  wire logic        ov_above_upper_i,
	input  wire logic        ov_above_lower_i,
	input  wire logic        uv_below_lower_i,
	input  wire logic        uv_above_upper_i,
	input  wire logic        mag_range_alarm_i,
	input  wire logic        cordic_ovf_alarm_i,
	input  wire logic        offset_comp_alarm_i,
	input  wire logic        osc_fail_alarm_i,
	input  wire logic        wd_kick_i,
	input  wire logic        overload_i,
	output logic      [11:0] dac_code_o,
	output logic             out_en_o,
	output logic             analog_mode_o
);
	logic [31:0] otp_mem [angle_map_pkg::OTP_WORDS];
	logic [13:0] angle_q;
	logic [11:0] mapped;
	logic        ov_fault, uv_fault, wd_fault;
	logic        req, wr_ok, cfg_hit, locked, band_high;
	logic        alarm_any, supply_off;
	logic [1:0]  cfg_idx;
	logic [11:0] next_dac;
	logic [31:0] next_rdata;

	map_cfg_if cfg_bus ();

	// Field views of the configuration words
	assign cfg_bus.angle_start_point =
		otp_mem[0][angle_map_pkg::F_LO +: angle_map_pkg::ANG_W];
	assign cfg_bus.angle_end_point   =
		otp_mem[0][angle_map_pkg::F_HI +: angle_map_pkg::ANG_W];
	assign cfg_bus.start_point_level =
		otp_mem[1][angle_map_pkg::F_LO +: angle_map_pkg::DAC_W];
	assign cfg_bus.end_point_level   =
		otp_mem[1][angle_map_pkg::F_HI +: angle_map_pkg::DAC_W];
	assign cfg_bus.clamp_low_level   =
		otp_mem[2][angle_map_pkg::F_LO +: angle_map_pkg::CLAMP_W]; // [RQ4]
	assign cfg_bus.clamp_high_level  =
		otp_mem[2][angle_map_pkg::F_HI +: angle_map_pkg::CLAMP_W]; // [RQ4]
	assign cfg_bus.wrap_transition_point =
		otp_mem[3][angle_map_pkg::F_LO +: angle_map_pkg::ANG_W];
	assign cfg_bus.invert = otp_mem[3][angle_map_pkg::F_INVERT];
	assign band_high      = otp_mem[3][angle_map_pkg::F_BAND];
	assign locked         = otp_mem[3][angle_map_pkg::F_LOCK];

	// Bus decode; the answer comes one edge after the request
	assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign cfg_hit = (wb_adr_i <= angle_map_pkg::ADR_CFG3)
		&& (wb_adr_i[1:0] == 2'h0);
	assign cfg_idx = wb_adr_i[3:2];
	assign wr_ok   = req && wb_we_i && cfg_hit && !locked; // [RQ18]

	always_ff @(posedge core_clk_i) begin
		if (reset_i)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= req;
	end

	// Configuration store: 4 x 32 bits, byte lanes honoured
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			otp_mem[0] <= angle_map_pkg::CFG0_DEF; // [RQ17]
			otp_mem[1] <= angle_map_pkg::CFG1_DEF;
			otp_mem[2] <= angle_map_pkg::CFG2_DEF;
			otp_mem[3] <= angle_map_pkg::CFG3_DEF;
		end else if (wr_ok) begin // [RQ17] [RQ20]
			for (int b = 0; b < 4; b++) begin
				if (wb_sel_i[b])
					otp_mem[cfg_idx][b*8 +: 8] <= wb_dat_i[b*8 +: 8];
			end
		end
	end

	// Read data; unmapped offsets read as zero
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (cfg_hit)
			next_rdata = otp_mem[cfg_idx];
		else if (wb_adr_i == angle_map_pkg::ADR_STATUS)
			next_rdata = {25'h0, analog_mode_o, out_en_o,
				alarm_any, overload_i, wd_fault, uv_fault, ov_fault};
		else if (wb_adr_i == angle_map_pkg::ADR_LIVE)
			next_rdata = {4'h0, dac_code_o, 2'h0, angle_q};
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i)
			wb_dat_o <= 32'h0000_0000;
		else if (req && !wb_we_i)
			wb_dat_o <= next_rdata;
	end

	// Angle code captured for readback
	always_ff @(posedge core_clk_i) begin
		if (reset_i)
			angle_q <= 14'h0000;
		else
			angle_q <= angle_i; // [RQ1]
	end

	map_core u_map (
		.core_clk_i (core_clk_i),
		.reset_i    (reset_i),
		.cfg        (cfg_bus.dst),
		.angle_i    (angle_i),
		.level_o    (mapped)
	);

	// Overvoltage: trip above upper, release once below lower
	level_qualifier #(.DET(OV_DET), .REC(OV_REC)) u_ov (
		.core_clk_i (core_clk_i),
		.reset_i    (reset_i),
		.bad_i      (ov_above_upper_i), // [RQ10]
		.good_i     (!ov_above_lower_i), // [RQ11]
		.fault_o    (ov_fault)
	);

	// Undervoltage: trip below lower, release once above upper
	level_qualifier #(.DET(UV_DET), .REC(UV_REC)) u_uv (
		.core_clk_i (core_clk_i),
		.reset_i    (reset_i),
		.bad_i      (uv_below_lower_i), // [RQ12]
		.good_i     (uv_above_upper_i), // [RQ13]
		.fault_o    (uv_fault)
	);

	// Watchdog: a missing kick for the full window is an error
	level_qualifier #(.DET(WD_DET), .REC(angle_map_pkg::WD_REC_CYC)) u_wd (
		.core_clk_i (core_clk_i),
		.reset_i    (reset_i),
		.bad_i      (!wd_kick_i), // [RQ14]
		.good_i     (wd_kick_i),
		.fault_o    (wd_fault)
	);

	// Internal alarms drive a band; supply and overload float the pin
	assign alarm_any = mag_range_alarm_i || cordic_ovf_alarm_i
		|| offset_comp_alarm_i || osc_fail_alarm_i || wd_fault; // [RQ21]
	assign supply_off = ov_fault || uv_fault;

	always_comb begin
		if (alarm_any)
			next_dac = band_high ? angle_map_pkg::FAIL_HIGH_CODE
				: angle_map_pkg::FAIL_LOW_CODE; // [RQ16] [RQ22]
		else
			next_dac = mapped; // [RQ2]
	end

	// Output code to the DAC, which takes the supply as reference
	always_ff @(posedge core_clk_i) begin
		if (reset_i)
			dac_code_o <= angle_map_pkg::FAIL_LOW_CODE;
		else
			dac_code_o <= next_dac; // [RQ2]
	end

	// Driver enable: off means high impedance at the pin
	always_ff @(posedge core_clk_i) begin
		if (reset_i)
			out_en_o <= 1'b0;
		else
			out_en_o <= !(supply_off || overload_i); // [RQ15] [RQ16]
	end

	// Analog mode follows the lock bit
	always_ff @(posedge core_clk_i) begin
		if (reset_i)
			analog_mode_o <= 1'b0;
		else
			analog_mode_o <= locked; // [RQ19]
	end

	// Check-only helpers: each supply condition and the missing heartbeat
	// counted apart from the qualifiers, so a miscount there shows up
	localparam int SUP_MAX   = OV_DET + OV_REC + UV_DET + UV_REC;
	localparam int SUP_W     = $clog2(SUP_MAX + 1);
	localparam int WD_W      = $clog2(WD_DET + 1);
	localparam int N_SUP     = 4;
	localparam int I_OV_TRIP = 0;
	localparam int I_OV_FREE = 1;
	localparam int I_UV_TRIP = 2;
	localparam int I_UV_FREE = 3;
	logic [N_SUP-1:0] sup_cond;
	logic [SUP_W-1:0] sup_run [N_SUP];
	logic [WD_W-1:0]  kick_gap;

	// Order follows the index names above
	assign sup_cond = {uv_above_upper_i, uv_below_lower_i,
		!ov_above_lower_i, ov_above_upper_i};

	// A run restarts on any gap and saturates, so it never wraps
	always_ff @(posedge core_clk_i) begin
		for (int k = 0; k < N_SUP; k++) begin
			if (reset_i || !sup_cond[k])
				sup_run[k] <= '0;
			else if (sup_run[k] != SUP_W'(SUP_MAX))
				sup_run[k] <= sup_run[k] + 1'b1;
		end
	end

	// Edges since the last heartbeat, held at the window length
	always_ff @(posedge core_clk_i) begin
		if (reset_i || wd_kick_i)
			kick_gap <= '0;
		else if (kick_gap != WD_W'(WD_DET))
			kick_gap <= kick_gap + 1'b1;
	end

	// Failure band edges as codes, in percent of full scale
	localparam int BAND_SPAN   = 100;
	localparam int BAND_LO_PCT = 4;
	localparam int BAND_HI_PCT = 96;
	localparam int CODE_FULL   = int'(angle_map_pkg::FAIL_HIGH_CODE);
	localparam logic [11:0] BAND_LO_TOP =
		12'(CODE_FULL * BAND_LO_PCT / BAND_SPAN);
	localparam logic [11:0] BAND_HI_BOT =
		12'(CODE_FULL * BAND_HI_PCT / BAND_SPAN);

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (reset_i);

	sequence s_locked_write;
		locked && req && wb_we_i;
	endsequence
	sequence s_ack_then_drop;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	// Clamps unchanged from the map stage to the output stage
	sequence s_clamp_settled;
		cfg_bus.clamp_low_level <= cfg_bus.clamp_high_level
		##1 !alarm_any && $stable(otp_mem[2])
		##1 $stable(otp_mem[2]);
	endsequence

	a_bus_answer: assert property (req |=> s_ack_then_drop)
		else $error("bus request not answered in one cycle");
	a_lock_freeze: assert property (s_locked_write |=> // [RQ18]
		$stable(otp_mem[0]) && $stable(otp_mem[1])
		&& $stable(otp_mem[2]) && $stable(otp_mem[3]))
		else $error("configuration changed while locked");
	a_ov_off: assert property (ov_fault |=> !out_en_o) // [RQ10]
		else $error("output enabled during overvoltage");
	a_uv_off: assert property (uv_fault |=> !out_en_o) // [RQ12]
		else $error("output enabled during undervoltage");
	a_short_hiz: assert property (overload_i |=> !out_en_o) // [RQ15]
		else $error("output driven during overload");
	a_recover_on: assert property ( // [RQ11]
		!ov_fault && !uv_fault && !overload_i |=> out_en_o)
		else $error("output not enabled with supply good");
	a_band_pick: assert property (alarm_any |=> // [RQ21]
		dac_code_o == (($past(band_high)) ? angle_map_pkg::FAIL_HIGH_CODE
		: angle_map_pkg::FAIL_LOW_CODE))
		else $error("alarm did not select the failure band");
	a_clamp_window: assert property ( // [RQ23]
		s_clamp_settled |-> dac_code_o[11:3] >= cfg_bus.clamp_low_level
		&& dac_code_o[11:3] <= cfg_bus.clamp_high_level)
		else $error("output code outside clamp window");
	a_mode_follow: assert property ($rose(locked) |=> analog_mode_o) // [RQ19]
		else $error("analog mode not selected after lock");

	// Supply faults never trip or release before their full run
	a_ov_qualify: assert property ( // [RQ10]
		$rose(ov_fault) |-> sup_run[I_OV_TRIP] >= SUP_W'(OV_DET))
		else $error("overvoltage fault raised before detection time");
	a_ov_release: assert property ( // [RQ11]
		$fell(ov_fault) |-> sup_run[I_OV_FREE] >= SUP_W'(OV_REC))
		else $error("overvoltage fault cleared before recovery time");
	a_uv_qualify: assert property ( // [RQ12]
		$rose(uv_fault) |-> sup_run[I_UV_TRIP] >= SUP_W'(UV_DET))
		else $error("undervoltage fault raised before detection time");
	a_uv_release: assert property ( // [RQ13]
		$fell(uv_fault) |-> sup_run[I_UV_FREE] >= SUP_W'(UV_REC))
		else $error("undervoltage fault cleared before recovery time");

	// Heartbeat loss is reported at the window's end, not before
	a_wd_deadline: assert property ( // [RQ14]
		kick_gap == WD_W'(WD_DET) |-> wd_fault)
		else $error("watchdog error not reported in time");
	a_wd_no_early: assert property ( // [RQ14]
		$rose(wd_fault) |-> kick_gap == WD_W'(WD_DET))
		else $error("watchdog error reported too early");

	// Configuration words read back what was written; holes read zero
	a_cfg_write: assert property ( // [RQ17]
		wr_ok && &wb_sel_i
		|=> otp_mem[$past(cfg_idx)] == $past(wb_dat_i))
		else $error("unlocked full-word write not stored");
	a_cfg_read: assert property ( // [RQ20]
		req && !wb_we_i && cfg_hit
		|=> wb_dat_o == $past(otp_mem[cfg_idx]))
		else $error("configuration word read back wrong");
	a_unmapped_zero: assert property ( // [RQ20]
		req && !wb_we_i && !cfg_hit
		&& wb_adr_i != angle_map_pkg::ADR_STATUS
		&& wb_adr_i != angle_map_pkg::ADR_LIVE
		|=> wb_dat_o == 32'h0000_0000)
		else $error("unmapped offset did not read as zero");
	a_live_read: assert property ( // [RQ1]
		req && !wb_we_i && wb_adr_i == angle_map_pkg::ADR_LIVE
		|=> wb_dat_o[angle_map_pkg::ANG_W-1:0] == $past(angle_q))
		else $error("live angle read back wrong");

	// Output stage: mapped level passes, bands stay inside their limits
	a_dac_map: assert property ( // [RQ2]
		!alarm_any |=> dac_code_o == $past(mapped))
		else $error("mapped level not passed to the converter");
	a_mode_hold: assert property (!locked |=> !analog_mode_o) // [RQ19]
		else $error("analog mode selected while unlocked");
	a_band_bounds: assert property ( // [RQ22]
		alarm_any |=> (dac_code_o <= BAND_LO_TOP
		|| dac_code_o >= BAND_HI_BOT))
		else $error("alarm output outside the failure bands");
endmodule

// ==== level_qualifier.sv ====
`timescale 1ns/1ps
module level_qualifier #(
	parameter int DET = 4,
	parameter int REC = 4
) (
	input  wire logic core_clk_i,
	input  wire logic reset_i,
	input  wire logic bad_i,
	input  wire logic good_i,
	output logic      fault_o
);
	localparam int MX = (DET > REC) ? DET : REC;
	localparam int CW = $clog2(MX + 1);
	localparam logic [CW-1:0] DET_END = CW'(DET - 1);
	localparam logic [CW-1:0] REC_END = CW'(REC - 1);
	angle_map_pkg::qual_state_t state;
	logic [CW-1:0] run;

	// A condition must persist for the full count; any gap restarts it
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			state <= angle_map_pkg::Q_OK;
			run   <= '0;
		end else begin
			case (state)
				angle_map_pkg::Q_OK: begin
					if (!bad_i)
						run <= '0;
					else if (run == DET_END) begin
						state <= angle_map_pkg::Q_FAULT;
						run   <= '0;
					end else
						run <= run + 1'b1;
				end
				angle_map_pkg::Q_FAULT: begin
					if (!good_i)
						run <= '0;
					else if (run == REC_END) begin
						state <= angle_map_pkg::Q_OK;
						run   <= '0;
					end else
						run <= run + 1'b1;
				end
				default: begin
					state <= angle_map_pkg::Q_OK;
					run   <= '0;
				end
			endcase
		end
	end
	assign fault_o = (state == angle_map_pkg::Q_FAULT);

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (reset_i);
	a_no_early_fault: assert property (!fault_o && !bad_i |=> !fault_o)
		else $error("fault raised without bad condition");
	a_no_early_clear: assert property (fault_o && !good_i |=> fault_o)
		else $error("fault cleared without good condition");
endmodule

// ==== map_cfg_if.sv ====
`timescale 1ns/1ps
interface map_cfg_if;
	logic [13:0] angle_start_point;
	logic [13:0] angle_end_point;
	logic [13:0] wrap_transition_point;
	logic [11:0] start_point_level;
	logic [11:0] end_point_level;
	logic [8:0]  clamp_low_level;
	logic [8:0]  clamp_high_level;
	logic        invert;
	modport src (output angle_start_point, angle_end_point,
		wrap_transition_point, start_point_level, end_point_level,
		clamp_low_level, clamp_high_level, invert);
	modport dst (input angle_start_point, angle_end_point,
		wrap_transition_point, start_point_level, end_point_level,
		clamp_low_level, clamp_high_level, invert);
endinterface

// ==== map_core.sv ====
`timescale 1ns/1ps
module map_core (
	input  wire logic        core_clk_i,
	input  wire logic        reset_i,
	map_cfg_if.dst           cfg,
	input  wire logic [13:0] angle_i,
	output logic      [11:0] level_o
);
	logic        [13:0] ang, rel, rs, re;
	logic signed [14:0] span, off;
	logic signed [12:0] dy;
	logic signed [27:0] prod, quo;
	logic signed [28:0] lvl;
	logic        [11:0] lo_b, hi_b, next_level;

	// Angles measured from the wrap point, so the step sits there
	always_comb begin
		ang = cfg.invert ? 14'h0000 - angle_i : angle_i; // [RQ9]
		rel = ang - cfg.wrap_transition_point; // [RQ8] [RQ7]
		rs  = cfg.angle_start_point - cfg.wrap_transition_point;
		re  = cfg.angle_end_point - cfg.wrap_transition_point; // [RQ3]
		span = $signed({1'b0, re}) - $signed({1'b0, rs});
		if (span <= 15'sh0000)
			span = 15'sh0001; // Degenerate range: avoid divide by zero
		off  = $signed({1'b0, rel}) - $signed({1'b0, rs});
		dy   = $signed({1'b0, cfg.end_point_level})
			- $signed({1'b0, cfg.start_point_level}); // [RQ5]
		prod = 28'(off * dy);
		quo  = prod / 28'(span); // [RQ6]
		lvl  = 29'(quo) + $signed({17'h00000, cfg.start_point_level});
		lo_b = {cfg.clamp_low_level, angle_map_pkg::CLAMP_LO_PAD};
		hi_b = {cfg.clamp_high_level, angle_map_pkg::CLAMP_HI_PAD};
		// Saturate to the clamp window on its top nine bits
		if (lvl < $signed({17'h00000, lo_b}))
			next_level = lo_b; // [RQ23] [RQ6]
		else if (lvl > $signed({17'h00000, hi_b}))
			next_level = hi_b; // [RQ23]
		else
			next_level = lvl[11:0];
	end

	// One pipeline stage keeps the divider off the output path
	always_ff @(posedge core_clk_i) begin
		if (reset_i)
			level_o <= angle_map_pkg::FAIL_LOW_CODE;
		else
			level_o <= next_level;
	end
endmodule

// ==== tb_angle_output_mapper.sv ====
`timescale 1ns/1ps
`define CHK(act, exp) begin n_compared++; if ((act) !== (exp)) begin \
	mismatches++; $display("unexpected at %0t: got %h want %h", \
	$time, act, exp); end end
module tb_angle_output_mapper;
	localparam int DET = 4;
	localparam int WDT = 16;
	typedef struct {logic [13:0] ang; logic [11:0] lvl;} row_t;
	logic        core_clk_i;
	logic        reset_i = 1'b1;
	logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'h0;
	logic [31:0] wdat = 32'h0, rdat, wb_dat_o;
	logic        wb_ack_o, out_en_o, analog_mode_o;
	logic [13:0] angle = 14'h0;
	logic        ov_up = 1'b0, ov_lo = 1'b0, uv_lo = 1'b0, uv_up = 1'b1;
	logic [3:0]  alarm = 4'h0;
	logic        kick = 1'b1, overload = 1'b0, pull_up = 1'b1;
	logic [11:0] dac_code_o, pin;
	int          mismatches = 0;
	int          n_compared = 0;
	// Mapping rows for start 1000/level 100, end 2000/level 900, clamps
	row_t rows[7] = '{'{14'h1000, 12'h100}, '{14'h2000, 12'h900},
		'{14'h1800, 12'h500}, '{14'h0FFF, 12'h100}, '{14'h0F00, 12'h080},
		'{14'h0000, 12'h080}, '{14'h3FFF, 12'hF87}};
	logic [31:0] cfg[4] = '{32'h2000_1000, 32'h0900_0100, 32'h01F0_0010,
		32'h0000_0000};
	logic [31:0] defs[4] = '{angle_map_pkg::CFG0_DEF,
		angle_map_pkg::CFG1_DEF, angle_map_pkg::CFG2_DEF,
		angle_map_pkg::CFG3_DEF};

	angle_output_mapper #(.OV_DET(DET), .OV_REC(DET), .UV_DET(DET),
		.UV_REC(DET), .WD_DET(WDT)) dut (
		.core_clk_i(core_clk_i), .reset_i(reset_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.angle_i(angle), .ov_above_upper_i(ov_up), .ov_above_lower_i(ov_lo),
		.uv_below_lower_i(uv_lo), .uv_above_upper_i(uv_up),
		.mag_range_alarm_i(alarm[0]), .cordic_ovf_alarm_i(alarm[1]),
		.offset_comp_alarm_i(alarm[2]), .osc_fail_alarm_i(alarm[3]),
		.wd_kick_i(kick), .overload_i(overload), .dac_code_o(dac_code_o),
		.out_en_o(out_en_o), .analog_mode_o(analog_mode_o));

	analog_load_model load (.dac_code_i(dac_code_o), .out_en_i(out_en_o),
		.pull_up_i(pull_up), .pin_level_o(pin));

	// Free-running 50 MHz clock
	initial begin
		core_clk_i = 1'b0;
		forever #10 core_clk_i = ~core_clk_i;
	end

	task automatic print_verdict();
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// One classic cycle; request held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge core_clk_i);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'hF; wdat <= d;
		// Only the bench watchdog ends a wait that never sees ack
		do begin
			@(posedge core_clk_i);
		end while (wb_ack_o !== 1'b1);
		rdat = wb_dat_o;
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
	endtask

	// Output path needs two edges; one spare edge for margin
	task automatic put_angle(input logic [13:0] a);
		@(posedge core_clk_i);
		angle <= a;
		repeat (3) @(posedge core_clk_i);
		#1;
	endtask

	task automatic wait_en(input int n, input logic e);
		repeat (n) @(posedge core_clk_i);
		#1;
		`CHK(out_en_o, e)
	endtask

	// Cuts a hang short; whole run needs well under 2000 cycles
	initial begin
		repeat (20000) @(posedge core_clk_i);
		mismatches++;
		print_verdict();
	end

	initial begin
		repeat (2) @(posedge core_clk_i);
		reset_i <= 1'b0;
		for (int i = 0; i < 4; i++) wb(1'b1, 8'(4 * i), cfg[i]);
		for (int i = 0; i < 4; i++) begin
			wb(1'b0, 8'(4 * i), 32'h0);
			`CHK(rdat, cfg[i])
		end
		wb(1'b0, 8'h20, 32'h0);
		`CHK(rdat, 32'h0)
		for (int i = 0; i < 7; i++) begin
			put_angle(rows[i].ang);
			`CHK(dac_code_o, rows[i].lvl)
			`CHK(pin, rows[i].lvl)
		end
		wb(1'b0, 8'h14, 32'h0);
		`CHK(rdat, 32'h0F87_3FFF)
		// Wrap point at 0800: output steps high to low across it
		wb(1'b1, 8'h0C, 32'h0000_0800);
		put_angle(14'h07FF);
		`CHK(dac_code_o, 12'hF87)
		put_angle(14'h0800);
		`CHK(dac_code_o, 12'h080)
		// Mirrored angle 3000 acts as 1000
		wb(1'b1, 8'h0C, 32'h0001_0000);
		put_angle(14'h3000);
		`CHK(dac_code_o, 12'h100)
		wb(1'b1, 8'h0C, 32'h0000_0000);
		put_angle(14'h1800);
		// Every alarm in both bands
		for (int b = 0; b < 2; b++) begin
			wb(1'b1, 8'h0C, b[0] ? 32'h0002_0000 : 32'h0);
			for (int i = 0; i < 4; i++) begin
				@(posedge core_clk_i);
				alarm <= 4'(1 << i);
				repeat (3) @(posedge core_clk_i);
				#1;
				`CHK(dac_code_o, b[0] ? 12'hFFF : 12'h000)
			end
			@(posedge core_clk_i);
			alarm <= 4'h0;
		end
		// Missing heartbeat lands in the chosen band
		@(posedge core_clk_i);
		kick <= 1'b0;
		repeat (WDT + 3) @(posedge core_clk_i);
		#1;
		`CHK(dac_code_o, 12'hFFF)
		@(posedge core_clk_i);
		kick <= 1'b1;
		put_angle(14'h1800);
		`CHK(dac_code_o, 12'h500)
		// Overload releases the pin to the pull-up
		@(posedge core_clk_i);
		overload <= 1'b1;
		wait_en(2, 1'b0);
		`CHK(pin, 12'hFFF)
		@(posedge core_clk_i);
		overload <= 1'b0;
		wait_en(2, 1'b1);
		// Overvoltage: detect, then recover
		@(posedge core_clk_i);
		ov_up <= 1'b1; ov_lo <= 1'b1;
		wait_en(DET - 1, 1'b1);
		wait_en(3, 1'b0);
		@(posedge core_clk_i);
		ov_up <= 1'b0; ov_lo <= 1'b0;
		wait_en(DET - 1, 1'b0);
		wait_en(3, 1'b1);
		// Undervoltage: detect, then recover
		@(posedge core_clk_i);
		uv_lo <= 1'b1; uv_up <= 1'b0;
		wait_en(DET - 1, 1'b1);
		wait_en(3, 1'b0);
		@(posedge core_clk_i);
		uv_lo <= 1'b0; uv_up <= 1'b1;
		wait_en(DET - 1, 1'b0);
		wait_en(3, 1'b1);
		// Lock freezes the setup and selects analog mode
		`CHK(analog_mode_o, 1'b0)
		wb(1'b1, 8'h0C, 32'h8000_0000);
		#1;
		`CHK(analog_mode_o, 1'b1)
		wb(1'b0, 8'h10, 32'h0);
		`CHK(rdat, 32'h0000_0060)
		wb(1'b1, 8'h00, 32'h0123_0456);
		wb(1'b0, 8'h00, 32'h0);
		`CHK(rdat, cfg[0])
		// Power cycle restores defaults
		@(posedge core_clk_i);
		reset_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		reset_i <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			wb(1'b0, 8'(4 * i), 32'h0);
			`CHK(rdat, defs[i])
		end
		print_verdict();
	end
endmodule
